// >>> dtd_top.sv
// Purpose: eight-channel toggle/dither code selection behind an APB slave
// Assumes: toggle pins and frame-end pin asynchronous, sampled by pclk
// Notes: one converter code per channel on dac_code
// Contract
// - each channel picks toggle or dither alone
// - two codes kept; clock selects A or B
// - toggle clock from pin 0-2 or soft bit
// - clock high gives A, low gives B
// - output follows both clock edges
// - enable register zero stops all toggling
// - A/B select bit steers code writes
// - mode 0, source 11 selects pin 2
// - enable bit per channel starts toggle/dither
// - dither samples are sine from table
// - dither clock from pin or soft bit
// - per-channel period and initial phase
// - output is A plus B times sample
// - new dither sample on rising edge
// - quarter table from 0 up to 1
// - mode 1, source 10 selects pin 1
// - toggle disabled connects register A at once
// - dither disabled finishes cycle then A
// - soft toggle bit changes at frame end
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "dtd_map.svh"
module dtd_top
  import dtd_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] toggle_pin,
  input wire logic chip_select_load,
  output logic [NCH-1:0][15:0] dac_code
);

  // ==========================================================
  // helpers
  function automatic logic addr_hit(input logic [7:0] a);
    logic h;
    h = (a[1:0] == 2'h0) && (a[7:5] != `DTD_RGN_CTRL) && (a[7:5] <= `DTD_RGN_OUT);
    h = h || (a == `DTD_ADDR_AB) || (a == `DTD_ADDR_TB) || (a == `DTD_ADDR_EN) || (a == `DTD_ADDR_STAT);
    return h;
  endfunction : addr_hit

  function automatic logic [5:0] per_step(input logic [2:0] per);
    logic [5:0] s;
    s = (per > `DTD_PER_MAX) ? `DTD_STEP_MIN : 6'(`DTD_STEP_FULL >> per);
    return s;
  endfunction : per_step

  function automatic dtd_code_t dith_code(input dtd_code_t a, input dtd_code_t b, input dtd_sine_t d);
    logic signed [23:0] prod;
    logic signed [24:0] sum;
    dtd_code_t r;
    prod = $signed({1'b0, b}) * d;
    sum = $signed({9'h000, a}) + 25'(prod >>> `DTD_SINE_FRAC);
    if (sum < 0)
      r = `DTD_RST_CODE;
    else if (sum > $signed({9'h000, `DTD_CODE_MAX}))
      r = `DTD_CODE_MAX;
    else
      r = sum[15:0];
    return r;
  endfunction : dith_code

  // ==========================================================
  // pin synchronisers and frame end
  logic [3:0] pins_s;
  logic cs_prev_r;
  logic cs_rise;

  dtd_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({chip_select_load, toggle_pin}),
    .q(pins_s)
  );

  assign cs_rise = pins_s[3] && !cs_prev_r;

  // ==========================================================
  // registers
  logic [7:0] ab_r, ab_nxt;
  logic [7:0] tb_pend_r, tb_pend_nxt;
  logic [7:0] tb_live_r, tb_live_nxt;
  logic [7:0] en_r, en_nxt;
  logic [NCH-1:0][`DTD_SET_W-1:0] set_r, set_nxt;
  logic [NCH-1:0][15:0] reg_a_r, reg_a_nxt;
  logic [NCH-1:0][15:0] reg_b_r, reg_b_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic err_r, err_nxt;
  logic wr;
  logic [2:0] wch;
  dtd_chst_e [NCH-1:0] st_r;

  assign wr = psel && penable && pwrite && addr_hit(paddr);
  assign wch = paddr[4:2];

  always_comb
  begin
    ab_nxt = ab_r;
    tb_pend_nxt = tb_pend_r;
    tb_live_nxt = cs_rise ? tb_pend_r : tb_live_r;
    en_nxt = en_r;
    set_nxt = set_r;
    reg_a_nxt = reg_a_r;
    reg_b_nxt = reg_b_r;
    prdata_nxt = prdata_r;
    err_nxt = err_r;
    if (wr)
    begin
      if (paddr == `DTD_ADDR_AB)
        ab_nxt = pwdata[7:0];
      if (paddr == `DTD_ADDR_TB)
        tb_pend_nxt = pwdata[7:0];
      if (paddr == `DTD_ADDR_EN)
        en_nxt = pwdata[7:0];
      if (paddr[7:5] == `DTD_RGN_SET)
        set_nxt[wch] = pwdata[`DTD_SET_W-1:0];
      if (paddr[7:5] == `DTD_RGN_CODE)
      begin
        if (ab_r[wch])
          reg_b_nxt[wch] = pwdata[15:0];
        else
          reg_a_nxt[wch] = pwdata[15:0];
      end
    end
    if (psel && !penable)
    begin
      err_nxt = !addr_hit(paddr);
      prdata_nxt = '0;
      if (paddr == `DTD_ADDR_AB)
        prdata_nxt[7:0] = ab_r;
      if (paddr == `DTD_ADDR_TB)
        prdata_nxt[15:0] = {tb_live_r, tb_pend_r};
      if (paddr == `DTD_ADDR_EN)
        prdata_nxt[7:0] = en_r;
      if (paddr == `DTD_ADDR_STAT)
        for (int c = 0; c < NCH; c++)
          prdata_nxt[c] = (st_r[c] != DTD_CH_IDLE);
      if (paddr[7:5] == `DTD_RGN_SET)
        prdata_nxt[`DTD_SET_W-1:0] = set_r[wch];
      if (paddr[7:5] == `DTD_RGN_CODE)
        prdata_nxt = {reg_b_r[wch], reg_a_r[wch]};
      if (paddr[7:5] == `DTD_RGN_OUT)
        prdata_nxt[15:0] = dac_code[wch];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ab_r <= `DTD_RST_BYTE;
      tb_pend_r <= `DTD_RST_BYTE;
      tb_live_r <= `DTD_RST_BYTE;
      en_r <= `DTD_RST_BYTE;
      set_r <= '0;
      reg_a_r <= '0;
      reg_b_r <= '0;
      prdata_r <= '0;
      err_r <= 1'b0;
      cs_prev_r <= 1'b0;
    end
    else
    begin
      ab_r <= ab_nxt;
      tb_pend_r <= tb_pend_nxt;
      tb_live_r <= tb_live_nxt;
      en_r <= en_nxt;
      set_r <= set_nxt;
      reg_a_r <= reg_a_nxt;
      reg_b_r <= reg_b_nxt;
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
      cs_prev_r <= pins_s[3];
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;

  // ==========================================================
  // channel engines
  logic [NCH-1:0] dither_clock_signal;
  logic [NCH-1:0] lvl_prev_r, lvl_prev_nxt;
  logic [NCH-1:0] rise;
  logic [NCH-1:0][5:0] n_r, n_nxt;
  logic [NCH-1:0][15:0] code_r, code_nxt;
  dtd_chst_e [NCH-1:0] st_nxt;
  dtd_sine_t [NCH-1:0] sine_val;

  dtd_sine_if sif[NCH]();

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    dtd_sine u_sine (
      .sif(sif[g])
    );
    assign sif[g].pos = 6'(n_r[g] + {set_r[g][`DTD_SET_PH], 4'h0});
    assign sine_val[g] = sif[g].val;
  end

  always_comb
  begin
    lvl_prev_nxt = lvl_prev_r;
    n_nxt = n_r;
    code_nxt = code_r;
    st_nxt = st_r;
    dither_clock_signal = '0;
    rise = '0;
    for (int c = 0; c < NCH; c++)
    begin
      unique case (set_r[c][`DTD_SET_TDSEL])
        `DTD_TDSEL_SW: dither_clock_signal[c] = tb_live_r[c];
        `DTD_TDSEL_PIN0: dither_clock_signal[c] = pins_s[0];
        `DTD_TDSEL_PIN1: dither_clock_signal[c] = pins_s[1];
        `DTD_TDSEL_PIN2: dither_clock_signal[c] = pins_s[2];
      endcase
      rise[c] = dither_clock_signal[c] && !lvl_prev_r[c];
      lvl_prev_nxt[c] = dither_clock_signal[c];
      unique case (st_r[c])
        DTD_CH_IDLE:
        begin
          if (en_r[c] && set_r[c][`DTD_SET_MODE] == DTD_MODE_TOGGLE)
            code_nxt[c] = dither_clock_signal[c] ? reg_a_r[c] : reg_b_r[c];
          else
            code_nxt[c] = reg_a_r[c];
          n_nxt[c] = `DTD_RST_POS;
          if (en_r[c] && set_r[c][`DTD_SET_MODE] == DTD_MODE_DITHER)
            st_nxt[c] = DTD_CH_RUN;
        end
        DTD_CH_RUN:
        begin
          if (rise[c])
          begin
            code_nxt[c] = dith_code(reg_a_r[c], reg_b_r[c], sine_val[c]);
            n_nxt[c] = 6'(n_r[c] + per_step(set_r[c][`DTD_SET_PER]));
          end
          if (set_r[c][`DTD_SET_MODE] == DTD_MODE_TOGGLE)
            st_nxt[c] = DTD_CH_IDLE;
          else if (!en_r[c])
            st_nxt[c] = DTD_CH_DRAIN;
        end
        DTD_CH_DRAIN:
        begin
          if (set_r[c][`DTD_SET_MODE] == DTD_MODE_TOGGLE)
            st_nxt[c] = DTD_CH_IDLE;
          else if (en_r[c])
            st_nxt[c] = DTD_CH_RUN;
          else if (rise[c] && n_r[c] == `DTD_RST_POS)
          begin
            code_nxt[c] = reg_a_r[c];
            st_nxt[c] = DTD_CH_IDLE;
          end
          else if (rise[c])
          begin
            code_nxt[c] = dith_code(reg_a_r[c], reg_b_r[c], sine_val[c]);
            n_nxt[c] = 6'(n_r[c] + per_step(set_r[c][`DTD_SET_PER]));
          end
        end
        default: st_nxt[c] = DTD_CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_prev_r <= '0;
      n_r <= '0;
      code_r <= '0;
      for (int c = 0; c < NCH; c++)
        st_r[c] <= DTD_CH_IDLE;
    end
    else
    begin
      lvl_prev_r <= lvl_prev_nxt;
      n_r <= n_nxt;
      code_r <= code_nxt;
      st_r <= st_nxt;
    end
  end

  assign dac_code = code_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_soft_frame_end: assert property (!$stable(tb_live_r) |-> $past(cs_rise))
    else $error("soft toggle bit changed outside frame end");

  chk_unmapped_err: assert property (psel && penable && !addr_hit(paddr) && $past(psel && !penable) |-> pslverr)
    else $error("unmapped access not flagged");

  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    sequence s_tog_armed;
      st_r[g] == DTD_CH_IDLE && en_r[g] && set_r[g][`DTD_SET_MODE] == DTD_MODE_TOGGLE;
    endsequence
    sequence s_drain_last;
      st_r[g] == DTD_CH_DRAIN && !en_r[g] && set_r[g][`DTD_SET_MODE] == DTD_MODE_DITHER
        && rise[g] && n_r[g] == `DTD_RST_POS;
    endsequence

    chk_toggle_high_a: assert property (s_tog_armed and dither_clock_signal[g] |=> dac_code[g] == $past(reg_a_r[g]))
      else $error("toggle high did not give code A");
    chk_toggle_low_b: assert property (s_tog_armed and !dither_clock_signal[g] |=> dac_code[g] == $past(reg_b_r[g]))
      else $error("toggle low did not give code B");
    chk_disable_gives_a: assert property (st_r[g] == DTD_CH_IDLE && !en_r[g] |=> dac_code[g] == $past(reg_a_r[g]))
      else $error("disabled channel not on code A");
    chk_code_write_ab: assert property (wr && paddr[7:5] == `DTD_RGN_CODE && wch == g && !ab_r[g]
      |=> reg_a_r[g] == $past(pwdata[15:0]) && $stable(reg_b_r[g]))
      else $error("code write missed register A");
    chk_dither_starts: assert property (st_r[g] == DTD_CH_IDLE && en_r[g] && set_r[g][`DTD_SET_MODE] == DTD_MODE_DITHER
      |=> st_r[g] == DTD_CH_RUN && n_r[g] == `DTD_RST_POS)
      else $error("dither did not start");
    chk_dither_step: assert property (st_r[g] == DTD_CH_RUN && rise[g]
      |=> n_r[g] == 6'($past(n_r[g]) + per_step($past(set_r[g][`DTD_SET_PER]))))
      else $error("dither position step wrong");
    chk_dither_hold: assert property (st_r[g] == DTD_CH_RUN && en_r[g] && !rise[g]
      && set_r[g][`DTD_SET_MODE] == DTD_MODE_DITHER |=> $stable(dac_code[g]) && $stable(n_r[g]))
      else $error("dither code moved without rising edge");
    chk_drain_finish: assert property (s_drain_last |=> st_r[g] == DTD_CH_IDLE && dac_code[g] == $past(reg_a_r[g]))
      else $error("dither drain did not end on code A");
    chk_sine_peaks: assert property ((sif[g].pos == `DTD_POS_PEAK |-> sine_val[g] == `DTD_SINE_ONE)
      and (sif[g].pos == `DTD_POS_TROUGH |-> sine_val[g] == -`DTD_SINE_ONE))
      else $error("sine peak value wrong");
  end

endmodule : dtd_top

// >>> dtd_map.svh
// Purpose: register map, field positions and constants of the toggle/dither block
// Assumes: byte addresses on an 8-bit APB address, one 32-bit word per register
// Notes: definitions only
`ifndef DTD_MAP_SVH
`define DTD_MAP_SVH

// ==========================================================
// register offsets
`define DTD_ADDR_AB 8'h00
`define DTD_ADDR_TB 8'h04
`define DTD_ADDR_EN 8'h08
`define DTD_ADDR_STAT 8'h0C
`define DTD_RGN_CTRL 3'h0
`define DTD_RGN_SET 3'h1
`define DTD_RGN_CODE 3'h2
`define DTD_RGN_OUT 3'h3

// ==========================================================
// channel setting fields
`define DTD_SET_W 14
`define DTD_SET_TDSEL 5:4
`define DTD_SET_MODE 6
`define DTD_SET_PER 10:8
`define DTD_SET_PH 13:12
`define DTD_TDSEL_SW 2'h0
`define DTD_TDSEL_PIN0 2'h1
`define DTD_TDSEL_PIN1 2'h2
`define DTD_TDSEL_PIN2 2'h3

// ==========================================================
// reset values and arithmetic constants
`define DTD_RST_BYTE 8'h00
`define DTD_RST_SET 14'h0000
`define DTD_RST_CODE 16'h0000
`define DTD_RST_POS 6'h00
`define DTD_CODE_MAX 16'hFFFF
`define DTD_SINE_FRAC 5
`define DTD_SINE_ONE 7'sh20
`define DTD_PER_MAX 3'h4
`define DTD_STEP_FULL 6'h10
`define DTD_STEP_MIN 6'h01
`define DTD_QUARTER 5'h10
`define DTD_POS_PEAK 6'h10
`define DTD_POS_TROUGH 6'h30

`endif

// >>> dtd_pkg.sv
// Purpose: shared types of the toggle/dither block
// Assumes: nothing
// Notes: numeric constants live in dtd_map.svh
package dtd_pkg;

  typedef enum logic [1:0]
  {
    DTD_CH_IDLE = 2'h0,
    DTD_CH_RUN = 2'h1,
    DTD_CH_DRAIN = 2'h3
  } dtd_chst_e;

  typedef enum logic
  {
    DTD_MODE_TOGGLE = 1'h0,
    DTD_MODE_DITHER = 1'h1
  } dtd_mode_e;

  typedef logic [15:0] dtd_code_t;
  typedef logic signed [6:0] dtd_sine_t;

endpackage : dtd_pkg

// >>> dtd_sine_if.sv
// Purpose: carries a sine table position and the looked-up sample
// Assumes: 64-step position around one full period
// Notes: none
`timescale 1ns/1ps
interface dtd_sine_if;
  import dtd_pkg::*;
  logic [5:0] pos;
  dtd_sine_t val;
  modport lookup (input pos, output val);
  modport user (output pos, input val);
endinterface : dtd_sine_if

// >>> dtd_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to pclk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module dtd_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule : dtd_sync

// >>> dtd_sine.sv
// Purpose: full-period sine samples built from a quarter-wave table
// Assumes: position counts 64 steps per period
// Notes: samples are signed with five fraction bits
`timescale 1ns/1ps
`include "dtd_map.svh"
module dtd_sine
  import dtd_pkg::*;
(
  dtd_sine_if.lookup sif
);

  // ==========================================================
  // quarter-wave magnitudes, one unit is 1/32
  function automatic logic [5:0] quarter_mag(input logic [4:0] idx);
    logic [5:0] m;
    m = 6'h00;
    unique case (idx)
      5'h00: m = 6'h00;
      5'h01: m = 6'h03;
      5'h02: m = 6'h06;
      5'h03: m = 6'h09;
      5'h04: m = 6'h0C;
      5'h05: m = 6'h0F;
      5'h06: m = 6'h12;
      5'h07: m = 6'h15;
      5'h08: m = 6'h18;
      5'h09: m = 6'h19;
      5'h0A: m = 6'h1B;
      5'h0B: m = 6'h1C;
      5'h0C: m = 6'h1E;
      5'h0D: m = 6'h1F;
      5'h0E: m = 6'h1F;
      5'h0F: m = 6'h20;
      5'h10: m = 6'h20;
      default: m = 6'h00;
    endcase
    return m;
  endfunction : quarter_mag

  // ==========================================================
  // symmetry: mirror odd quarters, negate second half
  logic [4:0] idx;
  logic [5:0] mag;

  always_comb
  begin
    idx = sif.pos[4] ? (`DTD_QUARTER - {1'b0, sif.pos[3:0]}) : {1'b0, sif.pos[3:0]};
    mag = quarter_mag(idx);
    sif.val = sif.pos[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

endmodule : dtd_sine

// >>> dtd_pin_src.sv
// Purpose: far-side model of the toggle pins and the frame-end pin
// Assumes: link clock of 200 ns period, idle low between frames
// Notes: pins change off the pclk grid, stand still outside frames
`timescale 1ns/1ps
module dtd_pin_src (
  output logic [2:0] toggle_pin,
  output logic chip_select_load
);
  // ==========================================================
  // idle levels
  initial
  begin
    toggle_pin = 3'h0;
    chip_select_load = 1'b0;
  end

  // ==========================================================
  // one half period of the link clock on one pin
  task automatic half(input int idx, input logic lvl);
    #5;
    toggle_pin[idx] = lvl;
    #95;
  endtask : half

  // ==========================================================
  // end of a command frame
  task automatic frame_end();
    #5;
    chip_select_load = 1'b1;
    #95;
    chip_select_load = 1'b0;
    #100;
  endtask : frame_end
endmodule : dtd_pin_src

// >>> dac_toggle_dither_control_bench.sv
// Purpose: self-checking bench of the toggle/dither block
// Assumes: zero-wait APB slave, 40 MHz pclk
// Notes: register rows first, then toggle, soft bit, dither, reset
`timescale 1ns/1ps
module dac_toggle_dither_control_bench;
  import dtd_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} dtd_row_s;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] toggle_pin;
  logic chip_select_load;
  logic [7:0][15:0] dac_code;
  int miscompares = 0;
  int num_checks = 0;
  dtd_row_s rows [6] = '{
    '{8'h00, 32'h0000005A, 32'h0000005A, 1'b0},
    '{8'h08, 32'h00000000, 32'h00000000, 1'b0},
    '{8'h24, 32'h00000030, 32'h00000030, 1'b0},
    '{8'h28, 32'h00000060, 32'h00000060, 1'b0},
    '{8'h1C, 32'h000000FF, 32'h00000000, 1'b1},
    '{8'h02, 32'h000000FF, 32'h00000000, 1'b1}};
  logic [15:0] exp2 [4] = '{16'h8000, 16'h8100, 16'h8000, 16'h7F00};
  logic [15:0] exp3 [4] = '{16'h8000, 16'h7F00, 16'h8000, 16'h8100};
  logic [15:0] exp4 [4] = '{16'h8000, 16'h8018, 16'h8030, 16'h8048};
  logic [15:0] exp5 [4] = '{16'hFFFF, 16'hFFFF, 16'hFFF0, 16'hFF30};

  dtd_top #(.NCH(8)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .toggle_pin(toggle_pin), .chip_select_load(chip_select_load), .dac_code(dac_code));
  dtd_pin_src pins (.toggle_pin(toggle_pin), .chip_select_load(chip_select_load));

  // ==========================================================
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // checking and bus tasks
  task automatic stop_test();
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_dac(input int ch, input logic [15:0] exp);
    cmp_reg({16'h0000, dac_code[ch]}, {16'h0000, exp});
  endtask : cmp_dac
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h00000000, q, e);
    cmp_reg(q, exp);
    cmp_reg({31'h00000000, e}, {31'h00000000, experr});
  endtask : rd

  // ==========================================================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q, rows[i].e);
    end
    // host loads A, B, setting, enable, then clocks the pin
    wr(8'h00, 32'h00000000);
    wr(8'h40, 32'h00002000);
    wr(8'h00, 32'h00000001);
    wr(8'h40, 32'h00001FFF);
    rd(8'h40, 32'h1FFF2000);
    wr(8'h20, 32'h00000030);
    pins.half(2, 1'b0);
    cmp_dac(0, 16'h2000);
    wr(8'h08, 32'h00000001);
    for (int k = 0; k < 2; k++)
    begin
      pins.half(2, 1'b1);
      cmp_dac(0, 16'h2000);
      pins.half(2, 1'b0);
      cmp_dac(0, 16'h1FFF);
    end
    wr(8'h08, 32'h00000000);
    repeat (2) @(posedge pclk);
    #1;
    cmp_dac(0, 16'h2000);
    // soft toggle bit on channel 1
    wr(8'h00, 32'h00000002);
    wr(8'h44, 32'h00002222);
    wr(8'h00, 32'h00000000);
    wr(8'h44, 32'h00001111);
    wr(8'h24, 32'h00000000);
    wr(8'h08, 32'h00000002);
    wr(8'h04, 32'h00000002);
    rd(8'h04, 32'h00000002);
    cmp_dac(1, 16'h2222);
    pins.frame_end();
    rd(8'h04, 32'h00000202);
    cmp_dac(1, 16'h1111);
    wr(8'h04, 32'h00000000);
    pins.frame_end();
    cmp_dac(1, 16'h2222);
    // dither on pin 1: ch2 N=4, ch3 N=4 at 180 deg, ch4 N=64
    wr(8'h00, 32'h00000000);
    for (int c = 2; c < 5; c++)
      wr(8'h40 + 8'(4 * c), 32'h00008000);
    wr(8'h00, 32'h0000001C);
    for (int c = 2; c < 5; c++)
      wr(8'h40 + 8'(4 * c), 32'h00000100);
    wr(8'h28, 32'h00000060);
    wr(8'h2C, 32'h00002060);
    wr(8'h30, 32'h00000460);
    wr(8'h08, 32'h0000001C);
    rd(8'h0C, 32'h0000001C);
    cmp_dac(2, 16'h8000);
    for (int k = 0; k < 4; k++)
    begin
      pins.half(1, 1'b1);
      cmp_dac(2, exp2[k]);
      cmp_dac(3, exp3[k]);
      cmp_dac(4, exp4[k]);
      pins.half(1, 1'b0);
      cmp_dac(4, exp4[k]);
      if (k == 1)
      begin
        wr(8'h08, 32'h00000010);
        rd(8'h0C, 32'h0000001C);
      end
    end
    // host keeps clocking until the cycle completes
    pins.half(1, 1'b1);
    cmp_dac(2, 16'h8000);
    pins.half(1, 1'b0);
    rd(8'h0C, 32'h00000010);
    // dither on pin 0: ch5 N=8 at 90 deg, sums clamp at full scale
    wr(8'h00, 32'h00000000);
    wr(8'h54, 32'h0000FFF0);
    wr(8'h00, 32'h00000020);
    wr(8'h54, 32'h00000100);
    wr(8'h34, 32'h00001150);
    wr(8'h08, 32'h00000030);
    for (int k = 0; k < 4; k++)
    begin
      pins.half(0, 1'b1);
      cmp_dac(5, exp5[k]);
      pins.half(0, 1'b0);
    end
    // mid-run reset clears codes and registers
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cmp_dac(0, 16'h0000);
    cmp_dac(4, 16'h0000);
    rd(8'h08, 32'h00000000);
    rd(8'h40, 32'h00000000);
    stop_test();
  end
endmodule : dac_toggle_dither_control_bench
